// ==== logic/ftc_defs.svh ====
`ifndef FTC_DEFS_SVH
`define FTC_DEFS_SVH
// Functional notes
// RULE1 - a flag set op drives one status flag to 1 in one cycle
// RULE2 - a flag clear op drives one status flag to 0; others untouched
// RULE3 - pre-decrement load: pointer minus one, then read at the new value
// RULE4 - post-increment load: read at the pointer, then pointer plus one
// RULE5 - displaced load reads at Y or Z plus displacement; pointer kept
// RULE6 - direct load reads the address held in the op, two cycles
// RULE7 - pre-decrement store: pointer minus one, then write there
// RULE8 - post-increment store: write at the pointer, then pointer plus one
// RULE9 - displaced store writes at Y or Z plus displacement; pointer kept
// RULE10 - direct store writes the address held in the op, two cycles
// RULE11 - program load reads at Z into dest or register zero, three cycles
// RULE12 - extended program load uses page:Z, increments it as one value
// RULE13 - push writes the source register onto the stack in two cycles
// RULE14 - pop reads the stack top into the destination in two cycles
// RULE15 - sleep issues in one cycle and requests the sleep logic
// RULE16 - watchdog restart issues in one cycle and pulses the watchdog
// RULE17 - break only signals the debug system
// RULE18 - stack pointer decrements after push, increments before pop
// RULE19 - X, Y, Z are 16-bit pairs of general registers

// register port map
`define FTC_A_STATUS 8'h20
`define FTC_A_PAGE   8'h21
`define FTC_A_SPLO   8'h22
`define FTC_A_SPHI   8'h23
`define FTC_A_STATE  8'h24
`define FTC_GPR_TOP  8'h1F
// reset values
`define FTC_SP_RST   16'h10FF
`define FTC_STAT_RST 8'h00
`define FTC_PAGE_RST 8'h00
// pointer pairs: low register index, high is low with bit 0 set
`define FTC_XLO      5'h1A
`define FTC_YLO      5'h1C
`define FTC_ZLO      5'h1E
`define FTC_HI_BIT   5'h01
`define FTC_REG_ZERO 5'h00
`define FTC_FLAG_I   3'h7
`define FTC_ONE16    16'h0001
`define FTC_ONE24    24'h000001
`endif

// ==== logic/ftc_pkg.sv ====
package ftc_pkg;
  typedef enum logic [3:0] {
    OP_NOP, OP_FLAGSET, OP_FLAGCLR, OP_INDLOAD, OP_DISPLOAD, OP_DIRLOAD,
    OP_INDSTORE, OP_DISPSTORE, OP_DIRSTORE, OP_PGMLOAD, OP_EXTLOAD,
    OP_PUSH, OP_POP, OP_SLEEP, OP_WDOG, OP_BRK
  } ftc_op_t;
  typedef enum logic [1:0] {MD_PLAIN, MD_POSTINC, MD_PREDEC} ftc_mode_t;
  typedef enum logic [1:0] {PTR_X, PTR_Y, PTR_Z} ftc_ptr_t;
  typedef enum logic [1:0] {S_IDLE, S_MEM, S_PGM1, S_PGM2} ftc_state_t;
endpackage

// ==== logic/ftc_core.sv ====
`timescale 1ns/100ps
`include "ftc_defs.svh"
module ftc_core (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // operation issue
  input  wire logic              opValid,
  input  wire ftc_pkg::ftc_op_t   opCode,
  input  wire ftc_pkg::ftc_mode_t opMode,
  input  wire ftc_pkg::ftc_ptr_t  opPtr,
  input  wire logic [4:0]        opDest,
  input  wire logic [4:0]        opSrc,
  input  wire logic [2:0]        opFlag,
  input  wire logic [5:0]        opDisp,
  input  wire logic [15:0]       opAddr,
  input  wire logic              opRegZero,
  output logic                   opReady,
  output logic                   opDone,
  // data memory and stack
  output logic [15:0]            dmAddr,
  output logic [7:0]             dmWdata,
  output logic                   dmWe,
  output logic                   dmRe,
  input  wire logic [7:0]        dmRdata,
  // program memory
  output logic [23:0]            pmAddr,
  output logic                   pmRe,
  input  wire logic [7:0]        pmRdata,
  // control requests
  output logic                   sleepReq,
  output logic                   wdogRestart,
  output logic                   breakReq,
  output logic                   intEnable,
  // register port
  input  wire logic [7:0]        busAddr,
  input  wire logic [7:0]        busWdata,
  input  wire logic              busWr,
  input  wire logic              busRd,
  output logic [7:0]             busRdata
);
  import ftc_pkg::*;

  logic [7:0]  gpr_r [32];
  logic [7:0]  status_r;
  logic [7:0]  page_r;
  logic [15:0] sp_r;
  logic [4:0]  dest_r;
  logic [15:0] dmAddr_r;
  logic [7:0]  dmWdata_r;
  logic        dmWe_r;
  logic        dmRe_r;
  logic [23:0] pmAddr_r;
  logic        pmRe_r;
  logic        sleep_r;
  logic        wdog_r;
  logic        brk_r;
  logic [7:0]  busRdata_r;
  ftc_state_t  state_r;
  ftc_state_t  state_nxt;

  logic        take;
  ftc_ptr_t    effSel;
  logic [4:0]  ptrLo;
  logic [4:0]  ptrHi;
  logic [15:0] ptrCur;
  logic [15:0] ptrNew;
  logic        ptrWr;
  logic [23:0] zExt;
  logic [23:0] zExtInc;
  logic [15:0] accAddr;
  logic        accRead;
  logic        accWrite;
  logic        isPgm;
  logic [15:0] spNew;

  // low register of a pointer pair; a bad code falls back to Z
  function automatic logic [4:0] ptrBase(ftc_ptr_t p);
    unique case (p)
      PTR_X:   ptrBase = `FTC_XLO;
      PTR_Y:   ptrBase = `FTC_YLO;
      default: ptrBase = `FTC_ZLO;
    endcase
  endfunction

  assign take = opValid && (state_r == S_IDLE);
  assign opReady = (state_r == S_IDLE);
  assign isPgm = (opCode == OP_PGMLOAD) || (opCode == OP_EXTLOAD);
  // pointer pair view; program loads always go through Z
  assign effSel = isPgm ? PTR_Z : opPtr;
  assign ptrLo = ptrBase(effSel);
  assign ptrHi = ptrLo | `FTC_HI_BIT;
  assign ptrCur = {gpr_r[ptrHi], gpr_r[ptrLo]}; // RULE19
  assign zExt = {page_r, ptrCur};
  assign zExtInc = zExt + `FTC_ONE24; // RULE12
  // address, access kind and pointer update for the op being taken
  always_comb begin
    accAddr = ptrCur;
    accRead = 1'b0;
    accWrite = 1'b0;
    ptrWr = 1'b0;
    ptrNew = ptrCur;
    spNew = sp_r;
    unique case (opCode)
      OP_INDLOAD, OP_INDSTORE: begin
        accRead = (opCode == OP_INDLOAD);
        accWrite = (opCode == OP_INDSTORE);
        if (opMode == MD_PREDEC) begin
          ptrNew = ptrCur - `FTC_ONE16; // RULE3 RULE7
          accAddr = ptrNew;
          ptrWr = 1'b1;
        end else if (opMode == MD_POSTINC) begin
          ptrNew = ptrCur + `FTC_ONE16; // RULE4 RULE8
          ptrWr = 1'b1;
        end
      end
      OP_DISPLOAD, OP_DISPSTORE: begin
        accRead = (opCode == OP_DISPLOAD);
        accWrite = (opCode == OP_DISPSTORE);
        accAddr = ptrCur + {10'h000, opDisp}; // RULE5 RULE9
      end
      OP_DIRLOAD: begin
        accRead = 1'b1;
        accAddr = opAddr; // RULE6
      end
      OP_DIRSTORE: begin
        accWrite = 1'b1;
        accAddr = opAddr; // RULE10
      end
      OP_PUSH: begin
        accWrite = 1'b1;
        accAddr = sp_r;
        spNew = sp_r - `FTC_ONE16; // RULE18
      end
      OP_POP: begin
        accRead = 1'b1;
        spNew = sp_r + `FTC_ONE16; // RULE18
        accAddr = spNew;
      end
      OP_PGMLOAD: begin
        if (opMode == MD_POSTINC) begin
          ptrNew = ptrCur + `FTC_ONE16; // RULE11
          ptrWr = 1'b1;
        end
      end
      OP_EXTLOAD: begin
        if (opMode == MD_POSTINC) begin
          ptrNew = zExtInc[15:0]; // RULE12
          ptrWr = 1'b1;
        end
      end
      OP_NOP, OP_FLAGSET, OP_FLAGCLR, OP_SLEEP, OP_WDOG, OP_BRK: begin
      end
    endcase
  end
  // sequencing: memory ops hold one extra cycle, program loads two
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      S_IDLE: begin
        if (take && (accRead || accWrite)) begin
          state_nxt = S_MEM;
        end else if (take && isPgm) begin
          state_nxt = S_PGM1;
        end
      end
      S_MEM:  state_nxt = S_IDLE;
      S_PGM1: state_nxt = S_PGM2;
      S_PGM2: state_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_r <= S_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end
  // last cycle of an op; single-cycle ops finish in their issue cycle
  assign opDone = (take && !accRead && !accWrite && !isPgm) ||
                  (state_r == S_MEM) || (state_r == S_PGM2);
  // data memory strobes stand for exactly the second cycle of the op
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      dmAddr_r <= 16'h0000;
      dmWdata_r <= 8'h00;
      dmWe_r <= 1'b0;
      dmRe_r <= 1'b0;
    end else if (take && (accRead || accWrite)) begin
      dmAddr_r <= accAddr;
      dmWdata_r <= gpr_r[opSrc]; // RULE13
      dmWe_r <= accWrite;
      dmRe_r <= accRead;
    end else begin
      dmWe_r <= 1'b0;
      dmRe_r <= 1'b0;
    end
  end
  // program memory: address held, read strobe in the second cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pmAddr_r <= 24'h000000;
      pmRe_r <= 1'b0;
    end else if (take && isPgm) begin
      pmAddr_r <= (opCode == OP_EXTLOAD) ? zExt : {8'h00, ptrCur}; // RULE11 RULE12
      pmRe_r <= 1'b1;
    end else begin
      pmRe_r <= 1'b0;
    end
  end
  // destination held for the write-back cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      dest_r <= `FTC_REG_ZERO;
    end else if (take) begin
      dest_r <= (isPgm && opRegZero) ? `FTC_REG_ZERO : opDest; // RULE11
    end
  end

  // general registers: port write, then pointer update, then load data;
  // a load into its own pointer byte lands a cycle later (two for program loads) and wins
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < 32; i++) begin
        gpr_r[i] <= 8'h00;
      end
    end else begin
      if (busWr && (busAddr <= `FTC_GPR_TOP)) begin
        gpr_r[busAddr[4:0]] <= busWdata;
      end
      if (take && ptrWr) begin
        gpr_r[ptrLo] <= ptrNew[7:0]; // RULE19
        gpr_r[ptrHi] <= ptrNew[15:8];
      end
      if ((state_r == S_MEM) && dmRe_r) begin
        gpr_r[dest_r] <= dmRdata; // RULE14
      end
      if (state_r == S_PGM2) begin
        gpr_r[dest_r] <= pmRdata; // RULE11
      end
    end
  end

  // status flags; an op in the same cycle as a port write wins
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      status_r <= `FTC_STAT_RST;
    end else begin
      if (busWr && (busAddr == `FTC_A_STATUS)) begin
        status_r <= busWdata;
      end
      if (take && (opCode == OP_FLAGSET)) begin
        status_r[opFlag] <= 1'b1; // RULE1
      end
      if (take && (opCode == OP_FLAGCLR)) begin
        status_r[opFlag] <= 1'b0; // RULE2
      end
    end
  end
  assign intEnable = status_r[`FTC_FLAG_I]; // RULE2

  // page extension and stack pointer
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      page_r <= `FTC_PAGE_RST;
      sp_r <= `FTC_SP_RST;
    end else begin
      if (busWr && (busAddr == `FTC_A_PAGE)) begin
        page_r <= busWdata;
      end
      if (busWr && (busAddr == `FTC_A_SPLO)) begin
        sp_r[7:0] <= busWdata;
      end
      if (busWr && (busAddr == `FTC_A_SPHI)) begin
        sp_r[15:8] <= busWdata;
      end
      if (take && (opCode == OP_EXTLOAD) && (opMode == MD_POSTINC)) begin
        page_r <= zExtInc[23:16]; // RULE12
      end
      if (take && ((opCode == OP_PUSH) || (opCode == OP_POP))) begin
        sp_r <= spNew; // RULE18
      end
    end
  end
  // one-cycle requests to the sleep, watchdog and debug units
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sleep_r <= 1'b0;
      wdog_r <= 1'b0;
      brk_r <= 1'b0;
    end else begin
      sleep_r <= take && (opCode == OP_SLEEP); // RULE15
      wdog_r <= take && (opCode == OP_WDOG); // RULE16
      brk_r <= take && (opCode == OP_BRK); // RULE17
    end
  end

  // register port read, data one cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      busRdata_r <= 8'h00;
    end else if (busRd) begin
      if (busAddr <= `FTC_GPR_TOP) begin
        busRdata_r <= gpr_r[busAddr[4:0]];
      end else begin
        unique case (busAddr)
          `FTC_A_STATUS: busRdata_r <= status_r;
          `FTC_A_PAGE:   busRdata_r <= page_r;
          `FTC_A_SPLO:   busRdata_r <= sp_r[7:0];
          `FTC_A_SPHI:   busRdata_r <= sp_r[15:8];
          `FTC_A_STATE:  busRdata_r <= {6'h00, state_r};
          default:       busRdata_r <= 8'h00;
        endcase
      end
    end
  end

  assign dmAddr = dmAddr_r;
  assign dmWdata = dmWdata_r;
  assign dmWe = dmWe_r;
  assign dmRe = dmRe_r;
  assign pmAddr = pmAddr_r;
  assign pmRe = pmRe_r;
  assign sleepReq = sleep_r;
  assign wdogRestart = wdog_r;
  assign breakReq = brk_r;
  assign busRdata = busRdata_r;

  // checks
  a_flag_set_one: assert property (@(posedge clk) disable iff (!rst_b) // RULE1
    take && (opCode == OP_FLAGSET) && !busWr |=>
    status_r == ($past(status_r) | (8'h01 << $past(opFlag))))
    else $error("flag set changed the wrong flags");
  a_flag_clr_one: assert property (@(posedge clk) disable iff (!rst_b) // RULE2
    take && (opCode == OP_FLAGCLR) && !busWr |=>
    status_r == ($past(status_r) & ~(8'h01 << $past(opFlag))))
    else $error("flag clear changed the wrong flags");
  a_predec_addr: assert property (@(posedge clk) disable iff (!rst_b) // RULE3
    take && (opCode == OP_INDLOAD) && (opMode == MD_PREDEC) |=>
    dmRe && (dmAddr == $past(ptrCur) - `FTC_ONE16))
    else $error("pre-decrement load used the wrong address");
  a_postinc_ptr: assert property (@(posedge clk) disable iff (!rst_b) // RULE8
    take && (opCode == OP_INDSTORE) && (opMode == MD_POSTINC) && !busWr |=>
    dmWe && (dmAddr == $past(ptrCur)) && ({gpr_r[$past(ptrHi)], gpr_r[$past(ptrLo)]} == dmAddr + `FTC_ONE16))
    else $error("post-increment store pointer wrong");
  a_disp_keep: assert property (@(posedge clk) disable iff (!rst_b) // RULE5
    take && (opCode == OP_DISPLOAD) && !busWr |=>
    (dmAddr == $past(ptrCur) + {10'h000, $past(opDisp)}) && ({gpr_r[$past(ptrHi)], gpr_r[$past(ptrLo)]} == $past(ptrCur)))
    else $error("displaced load address or pointer wrong");
  a_two_cycle: assert property (@(posedge clk) disable iff (!rst_b) // RULE6
    take && (opCode == OP_DIRLOAD) |=> dmRe && opDone ##1 opReady && !dmRe)
    else $error("direct load not two cycles");
  a_push_sp: assert property (@(posedge clk) disable iff (!rst_b) // RULE18
    take && (opCode == OP_PUSH) && !busWr |=>
    dmWe && (dmAddr == $past(sp_r)) && (sp_r == $past(sp_r) - `FTC_ONE16))
    else $error("push address or stack pointer wrong");
  a_pop_sp: assert property (@(posedge clk) disable iff (!rst_b) // RULE14
    take && (opCode == OP_POP) && !busWr |=>
    dmRe && (dmAddr == sp_r) && (sp_r == $past(sp_r) + `FTC_ONE16))
    else $error("pop address or stack pointer wrong");
  a_pgm_three: assert property (@(posedge clk) disable iff (!rst_b) // RULE11
    take && isPgm |=> pmRe && !opDone ##1 !pmRe && opDone ##1 opReady)
    else $error("program load not three cycles");
  a_wdog_pulse: assert property (@(posedge clk) disable iff (!rst_b) // RULE16
    take && (opCode == OP_WDOG) |-> opDone ##1 wdogRestart ##1 !wdogRestart)
    else $error("watchdog restart pulse wrong");
endmodule

// ==== tb/ftc_mem_model.sv ====
`timescale 1ns/100ps
module ftc_mem_model (
  // clock
  input  wire logic        clk,
  // data memory and stack
  input  wire logic [15:0] dmAddr,
  input  wire logic [7:0]  dmWdata,
  input  wire logic        dmWe,
  input  wire logic        dmRe,
  output logic [7:0]       dmRdata,
  // program memory
  input  wire logic [23:0] pmAddr,
  input  wire logic        pmRe,
  output logic [7:0]       pmRdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] dmLast = 8'h00;
  // preset contents so that no read can return an unknown
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = i[7:0] ^ i[15:8] ^ 8'hA5;
    end
  end
  // idle data lines flip every cycle so a stale byte never looks right
  always @(posedge clk) begin
    if (dmWe) begin
      mem[dmAddr] <= dmWdata;
    end
    dmLast <= dmRdata;
    pmRdata <= pmRe ? pmAddr[7:0] + pmAddr[15:8] + pmAddr[23:16] + 8'h3C : ~pmRdata;
  end
  // combinational read, as the core samples it in the strobe cycle
  assign dmRdata = dmRe ? mem[dmAddr] : ~dmLast;
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/100ps
module testbench;
  import ftc_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b, opValid, opRegZero, opReady, opDone;
  ftc_op_t     opCode;
  ftc_mode_t   opMode;
  ftc_ptr_t    opPtr;
  logic [4:0]  opDest, opSrc;
  logic [2:0]  opFlag;
  logic [5:0]  opDisp;
  logic [15:0] opAddr, dmAddr;
  logic [7:0]  dmWdata, dmRdata, pmRdata, busAddr, busWdata, busRdata;
  logic        dmWe, dmRe, pmRe, sleepReq, wdogRestart, breakReq, intEnable, busWr, busRd;
  logic [23:0] pmAddr;
  int          mismatches, tests_run, seed;
  logic [7:0]  gr [0:35];
  logic [7:0]  mref [0:65535];

  ftc_core dut (.clk(clk), .rst_b(rst_b), .opValid(opValid), .opCode(opCode), .opMode(opMode),
    .opPtr(opPtr), .opDest(opDest), .opSrc(opSrc), .opFlag(opFlag), .opDisp(opDisp), .opAddr(opAddr),
    .opRegZero(opRegZero), .opReady(opReady), .opDone(opDone), .dmAddr(dmAddr), .dmWdata(dmWdata),
    .dmWe(dmWe), .dmRe(dmRe), .dmRdata(dmRdata), .pmAddr(pmAddr), .pmRe(pmRe), .pmRdata(pmRdata),
    .sleepReq(sleepReq), .wdogRestart(wdogRestart), .breakReq(breakReq), .intEnable(intEnable),
    .busAddr(busAddr), .busWdata(busWdata), .busWr(busWr), .busRd(busRd), .busRdata(busRdata));
  ftc_mem_model mem (.clk(clk), .dmAddr(dmAddr), .dmWdata(dmWdata), .dmWe(dmWe), .dmRe(dmRe),
    .dmRdata(dmRdata), .pmAddr(pmAddr), .pmRe(pmRe), .pmRdata(pmRdata));

  // 100 ns clock
  always #50 clk = ~clk;

  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  // each bus access takes two cycles so no strobe is assigned twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    busAddr <= a;
    busWdata <= d;
    busWr <= 1'b1;
    @(posedge clk);
    busWr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    busAddr <= a;
    busRd <= 1'b1;
    @(posedge clk);
    busRd <= 1'b0;
    @(negedge clk);
    chk(busRdata, e, "read");
    @(posedge clk);
  endtask

  // registers, status, page and stack pointer against the model
  task automatic check_all;
    for (int a = 0; a < 36; a++) begin
      rd(a[7:0], gr[a]);
    end
    chk(intEnable, gr[32][7], "int enable");
  endtask

  // one operation with random fields; model first, then the observed port activity
  // k picks the mode per round, and the pointer for displaced ops, so every decoded mode is reached
  task automatic issue(input ftc_op_t c, input int k);
    logic [31:0] r;
    logic [15:0] p, ad;
    logic [23:0] ea, ga;
    logic [7:0]  ew, gw;
    logic [4:0]  d, s, dst;
    logic [2:0]  f, pul, gp;
    ftc_mode_t   m;
    ftc_ptr_t    pt;
    int          lo, lat, acc, gl, na, gk;
    r = $random(seed);
    ad = 16'($random(seed));
    {f, s, d} = r[12:0];
    m = ftc_mode_t'(k % 3);
    pt = ftc_ptr_t'(r[23:22] % 2'd3);
    if (c == OP_DISPLOAD || c == OP_DISPSTORE) pt = k[0] ? PTR_Z : PTR_Y;
    if (c == OP_PGMLOAD || c == OP_EXTLOAD) m = k[0] ? MD_POSTINC : MD_PLAIN;
    opValid <= 1'b1;
    opCode <= c;
    opMode <= m;
    opPtr <= pt;
    {opFlag, opSrc, opDest} <= r[12:0];
    opDisp <= r[18:13];
    opAddr <= ad;
    opRegZero <= r[19];
    lo = 26 + 2 * pt;
    p = {gr[lo + 1], gr[lo]};
    ew = gr[s];
    dst = d;
    lat = 2;
    acc = 0;
    pul = 3'b000;
    ea = 24'h000000;
    case (c)
      OP_FLAGSET: begin lat = 1; gr[32][f] = 1'b1; end
      OP_FLAGCLR: begin lat = 1; gr[32][f] = 1'b0; end
      OP_INDLOAD, OP_INDSTORE: begin
        if (m == MD_PREDEC) p = p - 16'h0001;
        ea = {8'h00, p};
        if (m == MD_POSTINC) p = p + 16'h0001;
        {gr[lo + 1], gr[lo]} = p;
        acc = c == OP_INDLOAD ? 1 : 2;
      end
      OP_DISPLOAD, OP_DISPSTORE: begin ea = {8'h00, p + r[18:13]}; acc = c == OP_DISPLOAD ? 1 : 2; end
      OP_DIRLOAD, OP_DIRSTORE: begin ea = {8'h00, ad}; acc = c == OP_DIRLOAD ? 1 : 2; end
      OP_PGMLOAD, OP_EXTLOAD: begin
        lat = 3;
        acc = 3;
        ea = {c == OP_EXTLOAD ? gr[33] : 8'h00, gr[31], gr[30]};
        ga = ea + 24'h000001;
        if (m == MD_POSTINC) {gr[31], gr[30]} = ga[15:0];
        if (m == MD_POSTINC && c == OP_EXTLOAD) gr[33] = ga[23:16];
        if (r[19]) dst = 5'h00;
      end
      OP_PUSH: begin acc = 2; ea = {8'h00, gr[35], gr[34]}; {gr[35], gr[34]} = ea[15:0] - 16'h0001; end
      OP_POP: begin acc = 1; {gr[35], gr[34]} = {gr[35], gr[34]} + 16'h0001; ea = {8'h00, gr[35], gr[34]}; end
      OP_SLEEP: begin lat = 1; pul = 3'b001; end
      OP_WDOG: begin lat = 1; pul = 3'b010; end
      OP_BRK: begin lat = 1; pul = 3'b100; end
      default: lat = 1;
    endcase
    if (acc == 1) gr[dst] = mref[ea[15:0]];
    if (acc == 2) mref[ea[15:0]] = ew;
    if (acc == 3) gr[dst] = ea[7:0] + ea[15:8] + ea[23:16] + 8'h3C;
    {gl, na, gk, ga, gw, gp} = '0;
    for (int n = 0; n < 5; n++) begin
      @(negedge clk);
      if (n == 0) chk(opReady, 1'b1, "ready");
      if (opDone === 1'b1 && gl == 0) gl = n + 1;
      if (dmRe === 1'b1 || dmWe === 1'b1 || pmRe === 1'b1) begin
        na++;
        gk = pmRe ? 3 : dmWe ? 2 : 1;
        ga = pmRe ? pmAddr : {8'h00, dmAddr};
        gw = dmWe ? dmWdata : 8'h00;
      end
      gp = gp | {breakReq, wdogRestart, sleepReq};
      @(posedge clk);
      opValid <= 1'b0;
    end
    chk(24'(gl), 24'(lat), "cycles");
    chk(24'(na), 24'(acc != 0), "strobes");
    chk(24'(gk), 24'(acc), "access kind");
    chk(ga, ea, "address");
    chk(gw, acc == 2 ? ew : 8'h00, "wdata");
    chk(gp, pul, "pulse");
  endtask

  task automatic summarize;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // main sequence: reset values, random register fill, unmapped access, every op kind
  initial begin
    logic [31:0] r;
    rst_b = 1'b0;
    seed = 32'he416;
    mismatches = 0;
    tests_run = 0;
    {opValid, busWr, busRd, opRegZero} = '0;
    {opDest, opSrc, opFlag, opDisp, opAddr, busAddr, busWdata} = '0;
    opCode = OP_NOP;
    opMode = MD_PLAIN;
    opPtr = PTR_X;
    for (int a = 0; a < 36; a++) gr[a] = 8'h00;
    {gr[35], gr[34]} = 16'h10FF;
    for (int i = 0; i < 65536; i++) mref[i] = i[7:0] ^ i[15:8] ^ 8'hA5;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    check_all();
    rd(8'h24, 8'h00);
    for (int a = 0; a < 36; a++) begin
      r = $random(seed);
      wr(a[7:0], r[7:0]);
      gr[a] = r[7:0];
    end
    // unmapped place: write dropped, reads as zero
    wr(8'h40, 8'hFF);
    rd(8'h40, 8'h00);
    check_all();
    for (int i = 0; i < 96; i++) begin
      issue(ftc_op_t'(i % 16), i / 16);
      check_all();
    end
    summarize();
  end

  // roughly 8000 cycles expected; cut off well beyond
  initial begin
    #2000000;
    mismatches++;
    summarize();
  end
endmodule
